// File: hw/call_timing_pkg.sv
// Functional notes
// RQ1: Extended indirect call: 3 bytes/14 states binary, 2 bytes/13 states source.
// RQ2: Long indirect call: 3 bytes/10 states binary, 2 bytes/9 states source.
// RQ3: Internal execution, internal odd destination adds one state.
// RQ4: External destination adds two states.
// RQ5: Interrupt-frame setting of 1 adds five states to a framed return.
// RQ6: All applicable surcharges add together onto the base count.
package call_timing_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int STATE_W = 5;
  localparam int BYTE_W = 3;

  // ****************************************
  // Instruction kinds
  // ****************************************
  typedef enum logic [1:0] {
    KIND_EXTENDED_CALL = 2'b00,
    KIND_LONG_CALL = 2'b01,
    KIND_FRAMED_RETURN = 2'b10,
    KIND_UNUSED = 2'b11
  } kind_t;

  // ****************************************
  // Lengths and base state counts
  // ****************************************
  localparam logic [BYTE_W-1:0] EXT_CALL_BYTES_BIN = 3'h3;
  localparam logic [BYTE_W-1:0] EXT_CALL_BYTES_SRC = 3'h2;
  localparam logic [STATE_W-1:0] EXT_CALL_STATES_BIN = 5'h0e;
  localparam logic [STATE_W-1:0] EXT_CALL_STATES_SRC = 5'h0d;
  localparam logic [BYTE_W-1:0] LONG_CALL_BYTES_BIN = 3'h3;
  localparam logic [BYTE_W-1:0] LONG_CALL_BYTES_SRC = 3'h2;
  localparam logic [STATE_W-1:0] LONG_CALL_STATES_BIN = 5'h0a;
  localparam logic [STATE_W-1:0] LONG_CALL_STATES_SRC = 5'h09;

  // ****************************************
  // Surcharges
  // ****************************************
  localparam logic [STATE_W-1:0] ODD_INTERNAL_EXTRA = 5'h01;
  localparam logic [STATE_W-1:0] EXTERNAL_DEST_EXTRA = 5'h02;
  localparam logic [STATE_W-1:0] FRAME_EXTRA = 5'h05;
  localparam logic FRAME_SETTING_ON = 1'b1;

  // ****************************************
  // Sequencer
  // ****************************************
  localparam logic [STATE_W-1:0] LAST_STATE = 5'h01;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_t;

endpackage : call_timing_pkg

// File: hw/cost_if.sv
`timescale 1ns/1ps
`default_nettype none
// Instruction description in, length and state cost out
interface cost_if;
  import call_timing_pkg::*;
  kind_t kind;
  logic source_mode;
  logic internal_exec;
  logic dest_external;
  logic dest_odd;
  logic frame_setting;
  logic legal;
  logic [BYTE_W-1:0] bytes;
  logic [STATE_W-1:0] states;
  modport calc (
    input kind, source_mode, internal_exec, dest_external, dest_odd,
    input frame_setting,
    output legal, bytes, states
  );
  modport user (
    output kind, source_mode, internal_exec, dest_external, dest_odd,
    output frame_setting,
    input legal, bytes, states
  );
endinterface : cost_if
`default_nettype wire

// File: hw/call_cost.sv
`timescale 1ns/1ps
`default_nettype none
module call_cost
  import call_timing_pkg::*;
#(
  parameter logic [BYTE_W-1:0] RETURN_BYTES = 3'h1,
  parameter logic [STATE_W-1:0] RETURN_BASE_STATES = 5'h07
) (
  cost_if.calc cost
);

  logic [STATE_W-1:0] base;
  logic [STATE_W-1:0] extra_odd;
  logic [STATE_W-1:0] extra_ext;
  logic [STATE_W-1:0] extra_frame;

  // ****************************************
  // Base cost per kind and mode
  // ****************************************
  always_comb begin
    cost.legal = 1'b1;
    cost.bytes = RETURN_BYTES;
    base = RETURN_BASE_STATES;
    unique case (cost.kind)
      KIND_EXTENDED_CALL: begin
        cost.bytes = cost.source_mode ? EXT_CALL_BYTES_SRC
                                      : EXT_CALL_BYTES_BIN; // RQ1
        base = cost.source_mode ? EXT_CALL_STATES_SRC
                                : EXT_CALL_STATES_BIN; // RQ1
      end
      KIND_LONG_CALL: begin
        cost.bytes = cost.source_mode ? LONG_CALL_BYTES_SRC
                                      : LONG_CALL_BYTES_BIN; // RQ2
        base = cost.source_mode ? LONG_CALL_STATES_SRC
                                : LONG_CALL_STATES_BIN; // RQ2
      end
      KIND_FRAMED_RETURN: begin
        cost.bytes = RETURN_BYTES;
        base = RETURN_BASE_STATES;
      end
      KIND_UNUSED: begin
        cost.legal = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Surcharges, summed onto the base
  // ****************************************
  // Odd penalty only bites with internal execution and internal target
  assign extra_odd = (cost.internal_exec && !cost.dest_external &&
                      cost.dest_odd) ? ODD_INTERNAL_EXTRA : '0; // RQ3
  assign extra_ext = cost.dest_external ? EXTERNAL_DEST_EXTRA : '0; // RQ4
  assign extra_frame = (cost.kind == KIND_FRAMED_RETURN &&
                        cost.frame_setting == FRAME_SETTING_ON)
                       ? FRAME_EXTRA : '0; // RQ5
  assign cost.states = base + extra_odd + extra_ext + extra_frame; // RQ6

endmodule : call_cost
`default_nettype wire

// File: hw/call_return_state_timing.sv
`timescale 1ns/1ps
`default_nettype none
module call_return_state_timing
  import call_timing_pkg::*;
#(
  parameter logic [BYTE_W-1:0] RETURN_BYTES = 3'h1,
  parameter logic [STATE_W-1:0] RETURN_BASE_STATES = 5'h07
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic START_IN,
  input wire logic [1:0] KIND_IN,
  input wire logic SOURCE_MODE_IN,
  input wire logic INTERNAL_EXEC_IN,
  input wire logic DEST_EXTERNAL_IN,
  input wire logic DEST_ODD_IN,
  input wire logic INTERRUPT_FRAME_SETTING_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic REFUSED_OUT,
  output logic [BYTE_W-1:0] BYTES_OUT,
  output logic [STATE_W-1:0] STATES_OUT
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Catch parameter sets that the sequencer cannot count, and a zero return length
  // Worst sum must fit the counter, else the count would wrap
  localparam int WORST = 32'(RETURN_BASE_STATES) + 32'(ODD_INTERNAL_EXTRA)
                       + 32'(EXTERNAL_DEST_EXTRA) + 32'(FRAME_EXTRA);
  // Calls never pay the frame surcharge; the other two summed for margin
  localparam int WORST_CALL = 32'(EXT_CALL_STATES_BIN)
                            + 32'(ODD_INTERNAL_EXTRA)
                            + 32'(EXTERNAL_DEST_EXTRA);
  generate
    if (WORST >= (1 << STATE_W)) begin : g_bad_base
      $error("Return base state count overflows the state counter");
    end
    if (WORST_CALL >= (1 << STATE_W)) begin : g_bad_call
      $error("Call state count overflows the state counter");
    end
    if (RETURN_BASE_STATES == '0) begin : g_zero_base
      $error("Return base state count must be at least one");
    end
    // A zero marker would leave the countdown stuck at its total and never end
    if (LAST_STATE == '0) begin : g_zero_last
      $error("Last state marker must be nonzero");
    end
    if (RETURN_BYTES == '0) begin : g_zero_bytes
      $error("Return length must be at least one byte");
    end
  endgenerate

  // ****************************************
  // Cost calculator
  // ****************************************
  // Pure logic on the live pins; only the taking edge stores
  // its result, so pins may change freely while busy
  cost_if cost ();

  // Pins into the calculator; kind 11 passes and is refused later
  assign cost.kind = kind_t'(KIND_IN);
  assign cost.source_mode = SOURCE_MODE_IN;
  assign cost.internal_exec = INTERNAL_EXEC_IN;
  assign cost.dest_external = DEST_EXTERNAL_IN;
  assign cost.dest_odd = DEST_ODD_IN;
  assign cost.frame_setting = INTERRUPT_FRAME_SETTING_IN;

  call_cost #(
    .RETURN_BYTES(RETURN_BYTES),
    .RETURN_BASE_STATES(RETURN_BASE_STATES)
  ) u_cost (
    .cost(cost)
  );

  // ****************************************
  // Request decode
  // ****************************************
  // One request at a time, N being its summed state count:
  //   taken at an edge, outputs valid just after that edge
  //   busy for cycles 1 to N, done in cycle N
  //   next request taken no earlier than the edge ending cycle N+1
  // Limitation: one idle cycle between requests, never back to back

  // Sequencer state
  seq_t seq_r, seq_nxt;
  logic busy_r, busy_nxt;
  logic [STATE_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;

  // Held result
  logic [STATE_W-1:0] states_r, states_nxt;
  logic [BYTE_W-1:0] bytes_r, bytes_nxt;

  // Refusal pulse
  logic refused_r, refused_nxt;

  // Decode
  logic idle;
  logic take;

  // Only an idle sequencer takes; nothing is ever queued
  // Take is the only event that loads the counter and the result
  assign idle = (seq_r == SEQ_IDLE);
  assign take = idle && START_IN && cost.legal;

  // ****************************************
  // State sequencer
  // ****************************************
  // Counts down to the marker, so the end test is against a constant
  // rather than against the stored total
  always_comb begin
    seq_nxt = seq_r;
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    unique case (seq_r)
      SEQ_IDLE: begin
        // Refused or absent requests leave the sequencer idle
        if (take) begin
          seq_nxt = SEQ_RUN;
          busy_nxt = 1'b1;
          cnt_nxt = cost.states; // RQ6
          // A one-state total is done in its first busy cycle
          done_nxt = (cost.states == LAST_STATE);
        end
      end
      SEQ_RUN: begin
        // Starts seen here are answered by the refusal group
        if (cnt_r == LAST_STATE) begin
          seq_nxt = SEQ_IDLE;
          busy_nxt = 1'b0;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r - LAST_STATE;
          // Done marks the final busy state of the instruction
          done_nxt = (cnt_r == LAST_STATE + LAST_STATE);
        end
      end
    endcase
  end

  // Synchronous reset; outputs read zero until the first request
  // Reset wins over a request at the same edge
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      seq_r <= SEQ_IDLE;
      busy_r <= 1'b0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      busy_r <= busy_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  // ****************************************
  // Result hold
  // ****************************************
  // Length and total stand until the next accepted request;
  // a refused request leaves them untouched
  always_comb begin
    states_nxt = states_r;
    bytes_nxt = bytes_r;
    if (take) begin
      states_nxt = cost.states; // RQ1
      bytes_nxt = cost.bytes; // RQ2
    end
  end

  // Registers only
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      states_r <= '0;
      bytes_r <= '0;
    end else begin
      states_r <= states_nxt;
      bytes_r <= bytes_nxt;
    end
  end

  // ****************************************
  // Refusal
  // ****************************************
  // A start held high pulses refused on every busy cycle, so
  // callers should pulse start for one cycle
  always_comb begin
    refused_nxt = 1'b0;
    if (START_IN && !idle) begin
      // Busy, the done cycle included
      refused_nxt = 1'b1;
    end else if (START_IN && !cost.legal) begin
      // Idle, but the kind has no cost
      refused_nxt = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= refused_nxt;
    end
  end

  // ****************************************
  // Outputs, all from flip-flops
  // ****************************************
  // Every pin a register: no decode glitches, one cycle of latency
  // Busy is its own flop, a copy of the sequencer state
  assign BUSY_OUT = busy_r;
  assign DONE_OUT = done_r;
  assign REFUSED_OUT = refused_r;
  assign BYTES_OUT = bytes_r;
  assign STATES_OUT = states_r;

endmodule : call_return_state_timing
`default_nettype wire

// File: sim/call_return_state_timing_chk.sv
`timescale 1ns/1ps
`default_nettype none
module call_return_state_timing_chk
  import call_timing_pkg::*;
#(
  parameter logic [BYTE_W-1:0] RETURN_BYTES = 3'h1,
  parameter logic [STATE_W-1:0] RETURN_BASE_STATES = 5'h07
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic START_IN,
  input wire logic [1:0] KIND_IN,
  input wire logic SOURCE_MODE_IN,
  input wire logic INTERNAL_EXEC_IN,
  input wire logic DEST_EXTERNAL_IN,
  input wire logic DEST_ODD_IN,
  input wire logic INTERRUPT_FRAME_SETTING_IN,
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT,
  input wire logic REFUSED_OUT,
  input wire logic [BYTE_W-1:0] BYTES_OUT,
  input wire logic [STATE_W-1:0] STATES_OUT
);
  // ****************************************
  // Accept decode and surcharges
  // ****************************************
  logic acc;
  logic [STATE_W-1:0] sm, ex, cnt_r, cnt_nxt;
  logic [BYTE_W-1:0] call_bytes;
  logic [STATE_W-1:0] ext_st, long_st, odd_st, far_st, ret_st;
  assign acc = START_IN && !BUSY_OUT && KIND_IN != 2'b11;
  assign sm = {4'h0, SOURCE_MODE_IN};
  // Odd penalty only when the target is internal
  assign ex = {4'h0, INTERNAL_EXEC_IN & ~DEST_EXTERNAL_IN & DEST_ODD_IN}
    + {3'h0, DEST_EXTERNAL_IN, 1'b0}
    + ((KIND_IN == 2'b10 && INTERRUPT_FRAME_SETTING_IN) ? 5'h05 : 5'h00);
  // Expected costs of the request on the pins, looked back on by one edge
  assign call_bytes = 3'h3 - sm[2:0];
  assign ext_st = 5'h0e - sm + ex;
  assign long_st = 5'h0a - sm + ex;
  assign odd_st = 5'h0b - sm;
  assign far_st = 5'h10 - sm;
  assign ret_st = RETURN_BASE_STATES + ex;
  // Busy cycles so far; counted, as lengths exceed repetition limits
  always_comb begin
    cnt_nxt = BUSY_OUT ? cnt_r + 5'h01 : 5'h00;
    if (RESET_IN) begin
      cnt_nxt = 5'h00;
    end
  end
  always_ff @(posedge REF_CLK_IN) begin
    cnt_r <= cnt_nxt;
  end
  default clocking @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  chk_ext_cost: assert property (acc && KIND_IN == 2'b00 |=>
    BYTES_OUT == $past(call_bytes) &&
    STATES_OUT == $past(ext_st)) else $error("ext call cost");
  chk_long_cost: assert property (acc && KIND_IN == 2'b01 |=>
    BYTES_OUT == $past(call_bytes) &&
    STATES_OUT == $past(long_st)) else $error("long call cost");
  chk_odd_extra: assert property (acc && KIND_IN == 2'b01 &&
    INTERNAL_EXEC_IN && DEST_ODD_IN && !DEST_EXTERNAL_IN
    |=> STATES_OUT == $past(odd_st)) else $error("odd surcharge");
  chk_far_extra: assert property (acc && KIND_IN == 2'b00 &&
    DEST_EXTERNAL_IN |=> STATES_OUT == $past(far_st))
    else $error("external surcharge");
  chk_frame_extra: assert property (acc && KIND_IN == 2'b10 &&
    INTERRUPT_FRAME_SETTING_IN |=> BYTES_OUT == RETURN_BYTES &&
    STATES_OUT == $past(ret_st)) else $error("frame cost");
  chk_busy_length: assert property (DONE_OUT |->
    cnt_r == STATES_OUT - 5'h01 ##1 !BUSY_OUT) else $error("busy length");
  cov_frame: cover property (acc && INTERRUPT_FRAME_SETTING_IN);
  cov_refused: cover property (REFUSED_OUT);
  cov_back: cover property (DONE_OUT ##2 acc);
endmodule : call_return_state_timing_chk
bind call_return_state_timing call_return_state_timing_chk #(
  .RETURN_BYTES(RETURN_BYTES), .RETURN_BASE_STATES(RETURN_BASE_STATES)
) u_chk (.*);
`default_nettype wire

// File: sim/call_return_state_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module call_return_state_timing_tb
  import call_timing_pkg::*;
;
  // ****************************************
  // Stimulus, model and checks
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] drv = 8'h00; // Start, kind, source, internal, far, odd, frame
  logic busy, done, refused;
  logic [BYTE_W-1:0] bytes;
  logic [STATE_W-1:0] states;
  int n_mismatch = 0;
  int n_compared = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  call_return_state_timing dut (.REF_CLK_IN(clk), .RESET_IN(rst),
    .START_IN(drv[7]), .KIND_IN(drv[6:5]), .SOURCE_MODE_IN(drv[4]),
    .INTERNAL_EXEC_IN(drv[3]), .DEST_EXTERNAL_IN(drv[2]),
    .DEST_ODD_IN(drv[1]), .INTERRUPT_FRAME_SETTING_IN(drv[0]),
    .BUSY_OUT(busy), .DONE_OUT(done), .REFUSED_OUT(refused),
    .BYTES_OUT(bytes), .STATES_OUT(states));
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // One instruction against the bench's own cost arithmetic
  task automatic run(input logic [6:0] c);
    int k, st, n, d;
    k = c[6:5];
    st = (k == 0 ? 14 : k == 1 ? 10 : 7) - (k < 2 ? int'(c[4]) : 0)
      + int'(c[3] & ~c[2] & c[1]) + 2 * int'(c[2]) + (k == 2 && c[0] ? 5 : 0);
    n = 0;
    d = 0;
    @(posedge clk);
    drv <= {1'b1, c};
    @(posedge clk);
    drv[7] <= 1'b0;
    #1;
    chk("bytes", 8'(k == 2 ? 1 : 3 - int'(c[4])), {5'h00, bytes});
    chk("states", 8'(st), {3'h0, states});
    while (busy === 1'b1 && n < 40) begin
      n++;
      if (done === 1'b1) d = n;
      @(posedge clk);
      #1;
    end
    chk("busy_len", 8'(st), 8'(n));
    chk("done_at", 8'(st), 8'(d));
    if (n >= 40) close_out();
  endtask : run
  initial begin
    logic [6:0] c;
    void'($urandom(32'h9058));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Every legal kind, mode and surcharge mix
    for (int i = 0; i < 96; i++) run(7'(i));
    $display("table test done");
    // Random legal instructions
    repeat (40) begin
      c = 7'($urandom);
      if (c[6:5] == 2'b11) c[6:5] = 2'b10;
      run(c);
    end
    $display("random test done");
    // Illegal kind while idle must start nothing
    @(posedge clk);
    drv <= 8'hff;
    @(posedge clk);
    drv[7] <= 1'b0;
    #1;
    chk("refused", 8'h01, {7'h00, refused});
    chk("idle", 8'h00, {7'h00, busy});
    // Start held into busy is refused; reset mid-run clears all
    @(posedge clk);
    drv <= 8'h80;
    repeat (2) @(posedge clk);
    drv[7] <= 1'b0;
    #1;
    chk("refused_busy", 8'h01, {7'h00, refused});
    chk("held_states", 8'h0e, {3'h0, states});
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset_states", 8'h00, {3'h0, states});
    @(posedge clk);
    rst <= 1'b0;
    run(7'h24);
    $display("refusal and reset test done");
    close_out();
  end
endmodule : call_return_state_timing_tb
`default_nettype wire
